// ### hdl/wosopt_defs.svh
// offsets, field positions, reset values and timing counts of the option block
`ifndef WOSOPT_DEFS_SVH
`define WOSOPT_DEFS_SVH

`define WOSOPT_OFS_OPTION 8'h00
`define WOSOPT_OFS_STATUS 8'h04
`define WOSOPT_OFS_LVSTAT 8'h08

`define WOSOPT_BIT_STOP_KEEP 7
`define WOSOPT_BIT_RST_ALLOW 6
`define WOSOPT_BIT_PWR_ON 5
`define WOSOPT_BIT_FAST_WAKE 4
`define WOSOPT_BIT_WD_SHORT 3
`define WOSOPT_BIT_STOP_ALLOW 1
`define WOSOPT_BIT_WD_OFF 0

`define WOSOPT_RST_OPTION 8'h60

`define WOSOPT_LV_FILTER_CYC 9
`define WOSOPT_WAKE_FAST_CYC 32
`define WOSOPT_WAKE_SLOW_CYC 4096
`define WOSOPT_WD_SHORT_CYC ((1 << 13) - (1 << 4))
`define WOSOPT_WD_LONG_CYC ((1 << 18) - (1 << 4))

`endif

// ### hdl/wosopt_pkg.sv
// types shared by the option block
package wosopt_pkg;
	typedef enum logic [1:0] {
		WOSOPT_RESP_OKAY = 2'b00,
		WOSOPT_RESP_SLVERR = 2'b10
	} wosopt_resp_t;
	typedef enum logic [2:0] {
		WOSOPT_LV_IDLE = 3'b001,
		WOSOPT_LV_FILT = 3'b010,
		WOSOPT_LV_HOLD = 3'b100
	} wosopt_lv_t;
endpackage

// ### hdl/wosopt_lv_monitor.sv
// low-voltage monitor sequencer: filter, reset hold and stop gating
`include "wosopt_defs.svh"
module wosopt_lv_monitor
	import wosopt_pkg::*;
#(
	parameter int FILTER_CYC = `WOSOPT_LV_FILTER_CYC
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic power_on,
	input wire logic reset_allow,
	input wire logic stop_keep,
	input wire logic in_stop,
	input wire logic below_falling,
	input wire logic above_rising,
	output logic lv_reset,
	output logic lv_active,
	output logic lv_holding
);
	initial begin
		if (FILTER_CYC < 2 || FILTER_CYC > 255)
			$error("FILTER_CYC out of range");
	end

	wosopt_lv_t state_ff;
	wosopt_lv_t nxt_state;
	logic [7:0] cnt_ff;
	logic run;

	// monitor runs if powered, and in stop only if stop_keep is set
	assign run = power_on && (!in_stop || stop_keep);

	// state sequencing
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			WOSOPT_LV_IDLE: begin
				if (run && below_falling)
					nxt_state = WOSOPT_LV_FILT;
			end
			WOSOPT_LV_FILT: begin
				if (!run || !below_falling)
					nxt_state = WOSOPT_LV_IDLE;
				else if (cnt_ff == 8'(FILTER_CYC - 1) && reset_allow)
					nxt_state = WOSOPT_LV_HOLD;
			end
			WOSOPT_LV_HOLD: begin
				if (above_rising)
					nxt_state = WOSOPT_LV_IDLE;
			end
			default: nxt_state = WOSOPT_LV_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst)
			state_ff <= WOSOPT_LV_IDLE;
		else
			state_ff <= nxt_state;
	end

	// low-supply samples seen so far, the entry sample counted as one,
	// so the trip falls on the sample that completes the run
	always_ff @(posedge clk) begin
		if (srst || nxt_state != WOSOPT_LV_FILT)
			cnt_ff <= 8'h00;
		else if (state_ff != WOSOPT_LV_FILT)
			cnt_ff <= 8'h01;
		else if (cnt_ff != 8'(FILTER_CYC - 1))
			cnt_ff <= cnt_ff + 8'h01;
	end

	// reset request stays up until the rising trip is seen
	always_ff @(posedge clk) begin
		if (srst)
			lv_reset <= 1'b0;
		else
			lv_reset <= (nxt_state == WOSOPT_LV_HOLD);
	end

	assign lv_active = run;
	assign lv_holding = (state_ff == WOSOPT_LV_HOLD);
endmodule

// ### hdl/wosopt_top.sv
// write-once system option register with AXI4-Lite slave and outputs
`include "wosopt_defs.svh"
module wosopt_top
	import wosopt_pkg::*;
#(
	parameter int FILTER_CYC = `WOSOPT_LV_FILTER_CYC,
	parameter int WAKE_SLOW_CYC = `WOSOPT_WAKE_SLOW_CYC,
	parameter int WD_LONG_CYC = `WOSOPT_WD_LONG_CYC
) (
	input wire logic clk,
	input wire logic srst,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// supply comparators, asynchronous pins
	input wire logic supply_below_falling,
	input wire logic supply_above_rising,
	// stop sequencer
	input wire logic in_stop,
	output logic [18:0] stop_wake_cycles,
	// watchdog
	output logic watchdog_off,
	output logic [18:0] watchdog_period_cycles,
	// low-voltage monitor
	output logic monitor_power_on,
	output logic monitor_reset_allow,
	output logic monitor_stop_keep,
	output logic monitor_active,
	output logic low_voltage_reset,
	// opcode decoder
	output logic stop_allow
);
	localparam logic [18:0] WAKE_FAST = 19'(`WOSOPT_WAKE_FAST_CYC);
	localparam logic [18:0] WAKE_SLOW = 19'(WAKE_SLOW_CYC);
	localparam logic [18:0] WD_SHORT = 19'(`WOSOPT_WD_SHORT_CYC);
	localparam logic [18:0] WD_LONG = 19'(WD_LONG_CYC);

	initial begin
		if (WAKE_SLOW_CYC < 1 || WAKE_SLOW_CYC >= (1 << 19))
			$error("WAKE_SLOW_CYC out of range");
		if (WD_LONG_CYC < 1 || WD_LONG_CYC >= (1 << 19))
			$error("WD_LONG_CYC out of range");
	end

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [1:0] below_sync_ff;
	logic [1:0] above_sync_ff;

	// two flops per comparator pin
	always_ff @(posedge clk) begin
		if (srst) begin
			below_sync_ff <= 2'b00;
			above_sync_ff <= 2'b00;
		end else begin
			below_sync_ff <= {below_sync_ff[0], supply_below_falling};
			above_sync_ff <= {above_sync_ff[0], supply_above_rising};
		end
	end

	// ************************************************************
	// option register
	// ************************************************************
	logic [7:0] option_ff;
	logic written_ff;
	logic aw_held_ff;
	logic w_held_ff;
	logic [7:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic wr_fire;
	logic wr_hit;
	logic wr_take;

	function automatic logic decode_ok(input logic [7:0] a);
		decode_ok = (a == `WOSOPT_OFS_OPTION) ||
			(a == `WOSOPT_OFS_STATUS) || (a == `WOSOPT_OFS_LVSTAT);
	endfunction

	// address and data are captured in either order
	assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
	assign s_axi_wready = !w_held_ff && !s_axi_bvalid;

	always_ff @(posedge clk) begin
		if (srst) begin
			aw_held_ff <= 1'b0;
			awaddr_ff <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_ff <= 1'b1;
			awaddr_ff <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_held_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			w_held_ff <= 1'b0;
			wdata_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_ff <= 1'b1;
			wdata_ff <= s_axi_wdata;
			wstrb_ff <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_held_ff <= 1'b0;
		end
	end

	assign wr_fire = aw_held_ff && w_held_ff;
	assign wr_hit = wr_fire && (awaddr_ff == `WOSOPT_OFS_OPTION);
	// only the first write with lane 0 enabled counts
	assign wr_take = wr_hit && wstrb_ff[0] && !written_ff;

	// default value until the single write, then frozen until reset
	always_ff @(posedge clk) begin
		if (srst)
			option_ff <= `WOSOPT_RST_OPTION;
		else if (wr_take)
			option_ff <= wdata_ff[7:0];
	end

	always_ff @(posedge clk) begin
		if (srst)
			written_ff <= 1'b0;
		else if (wr_take)
			written_ff <= 1'b1;
	end

	// write response: okay for known offsets, error otherwise
	always_ff @(posedge clk) begin
		if (srst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= WOSOPT_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= decode_ok(awaddr_ff) ? WOSOPT_RESP_OKAY :
				WOSOPT_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ************************************************************
	// read path
	// ************************************************************
	logic lv_reset;
	logic lv_active;
	logic lv_holding;

	assign s_axi_arready = !s_axi_rvalid;

	// registered read data, stable until rready
	always_ff @(posedge clk) begin
		if (srst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= WOSOPT_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= decode_ok(s_axi_araddr) ? WOSOPT_RESP_OKAY :
				WOSOPT_RESP_SLVERR;
			unique case (s_axi_araddr)
				`WOSOPT_OFS_OPTION: s_axi_rdata <= {24'h000000, option_ff};
				`WOSOPT_OFS_STATUS: s_axi_rdata <= {31'h0, written_ff};
				`WOSOPT_OFS_LVSTAT: s_axi_rdata <=
					{29'h0, lv_holding, lv_active, lv_reset};
				default: s_axi_rdata <= 32'h0000_0000;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ************************************************************
	// option outputs
	// ************************************************************
	// decoded option bits toward their consumers
	always_ff @(posedge clk) begin
		if (srst) begin
			stop_wake_cycles <= WAKE_SLOW;
			watchdog_period_cycles <= WD_LONG;
		end else begin
			stop_wake_cycles <= option_ff[`WOSOPT_BIT_FAST_WAKE] ?
				WAKE_FAST : WAKE_SLOW;
			watchdog_period_cycles <= option_ff[`WOSOPT_BIT_WD_SHORT] ?
				WD_SHORT : WD_LONG;
		end
	end

	assign watchdog_off = option_ff[`WOSOPT_BIT_WD_OFF];
	assign stop_allow = option_ff[`WOSOPT_BIT_STOP_ALLOW];
	assign monitor_power_on = option_ff[`WOSOPT_BIT_PWR_ON];
	assign monitor_reset_allow = option_ff[`WOSOPT_BIT_RST_ALLOW];
	assign monitor_stop_keep = option_ff[`WOSOPT_BIT_STOP_KEEP];
	assign monitor_active = lv_active;
	assign low_voltage_reset = lv_reset;

	// ************************************************************
	// low-voltage monitor
	// ************************************************************
	wosopt_lv_monitor #(
		.FILTER_CYC(FILTER_CYC)
	) u_lv (
		.clk(clk),
		.srst(srst),
		.power_on(monitor_power_on),
		.reset_allow(monitor_reset_allow),
		.stop_keep(monitor_stop_keep),
		.in_stop(in_stop),
		.below_falling(below_sync_ff[1]),
		.above_rising(above_sync_ff[1]),
		.lv_reset(lv_reset),
		.lv_active(lv_active),
		.lv_holding(lv_holding)
	);
endmodule

// ### tb/wosopt_checker.sv
// port checker of the option block
module wosopt_checker (
	input wire logic clk,
	input wire logic srst,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic supply_below_falling,
	input wire logic supply_above_rising,
	input wire logic in_stop,
	input wire logic watchdog_off,
	input wire logic monitor_power_on,
	input wire logic monitor_reset_allow,
	input wire logic monitor_stop_keep,
	input wire logic monitor_active,
	input wire logic low_voltage_reset,
	input wire logic stop_allow
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	logic [3:0] run_ff;
	logic [2:0] up_ff;
	logic [4:0] opt;
	// the five single-bit option outputs seen as one word
	assign opt = {watchdog_off, stop_allow, monitor_power_on,
		monitor_reset_allow, monitor_stop_keep};
	// falling-pin run length and rising-pin history, sync delay allowed
	always_ff @(posedge clk) begin
		up_ff <= srst ? 3'h0 : {up_ff[1:0], supply_above_rising};
		if (srst || !supply_below_falling) begin
			run_ff <= 4'h0;
		end else if (run_ff != 4'hF) begin
			run_ff <= run_ff + 4'h1;
		end
	end
	// ****************
	// checks
	// ****************
	sequence s_trip;
		run_ff == 4'h9 && monitor_active && monitor_reset_allow;
	endsequence
	property p_trip; s_trip |-> ##[1:5] low_voltage_reset; endproperty
	a_trip: assert property (p_trip)
		else $error("low voltage reset missing");
	property p_rel; $fell(low_voltage_reset) |-> up_ff != 3'h0; endproperty
	a_rel: assert property (p_rel)
		else $error("reset released early");
	property p_blk;
		!monitor_reset_allow |-> !$rose(low_voltage_reset); endproperty
	a_blk: assert property (p_blk)
		else $error("blocked reset passed");
	property p_act; monitor_active ==
		(monitor_power_on && (!in_stop || monitor_stop_keep)); endproperty
	a_act: assert property (p_act)
		else $error("monitor activity wrong");
	property p_opt; !$rose(s_axi_bvalid) |-> $stable(opt); endproperty
	a_opt: assert property (p_opt)
		else $error("options moved without write");
	property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	a_bhold: assert property (p_bhold)
		else $error("write answer dropped");
	property p_rhold; s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_rhold: assert property (p_rhold)
		else $error("read answer moved");
	property p_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_busy: assert property (p_busy)
		else $error("write taken while answering");
endmodule
bind wosopt_top wosopt_checker u_chk (.clk, .srst, .s_axi_awready,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .supply_below_falling,
	.supply_above_rising, .in_stop, .watchdog_off, .monitor_power_on,
	.monitor_reset_allow, .monitor_stop_keep, .monitor_active,
	.low_voltage_reset, .stop_allow);

// ### tb/tb_top.sv
// bench of the option block
module tb_top
	import wosopt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SLOW = 64;
	localparam int LONG = 200;
	logic clk, srst, in_stop, below, above, done_m, s_axi_awvalid, s_axi_wvalid;
	logic [7:0] s_axi_awaddr, s_axi_araddr, m;
	logic [2:0] lv_m;
	logic [31:0] s_axi_wdata, s_axi_rdata, v;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic watchdog_off, stop_allow, monitor_power_on, monitor_reset_allow;
	logic monitor_stop_keep, monitor_active, low_voltage_reset;
	logic [18:0] stop_wake_cycles, watchdog_period_cycles;
	int n_fail, check_count, n;
	integer seed;
	`define CHK(g, e) check(g, e)
	wosopt_top #(.WAKE_SLOW_CYC(SLOW), .WD_LONG_CYC(LONG)) dut (.clk, .srst,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .supply_below_falling(below), .in_stop,
		.supply_above_rising(above), .stop_wake_cycles, .watchdog_off,
		.watchdog_period_cycles, .monitor_power_on, .monitor_reset_allow,
		.monitor_stop_keep, .monitor_active, .low_voltage_reset, .stop_allow);
	// compare and count
	task check(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// one bus cycle, write when w is high, checked against the model
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		logic [2:0] t;
		logic [31:0] x;
		logic [1:0] r;
		logic [31:0] e;
		@(posedge clk);
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= {a, a, d, s};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
		{s_axi_arvalid, s_axi_rready} <= {2{!w}};
		t = 3'h0;
		n = 0;
		while (!t[2]) begin
			@(negedge clk);
			t = t | (w ? {s_axi_bvalid, s_axi_wready, s_axi_awready} :
				{s_axi_rvalid, 1'b1, s_axi_arready});
			{x, r} = {s_axi_rdata, w ? s_axi_bresp : s_axi_rresp};
			@(posedge clk);
			s_axi_awvalid <= w && !t[0];
			s_axi_wvalid <= w && !t[1];
			s_axi_arvalid <= !w && !t[0];
			n++;
			if (n > 200) begin
				n_fail++;
				close_out();
			end
		end
		{s_axi_bready, s_axi_rready} <= 2'b00;
		e = (a < 8'd12 && a[1:0] == 2'b00) ? WOSOPT_RESP_OKAY :
			WOSOPT_RESP_SLVERR;
		`CHK(r, e);
		e = (a == 0) ? m : (a == 4) ? done_m : (a == 8) ? lv_m : 0;
		if (!w) `CHK(x, e);
		if (w && a == 0 && s[0] && !done_m) {m, done_m} = {d[7:0], 1'b1};
	endtask
	// option outputs against the model
	task chk_out;
		@(negedge clk);
		`CHK(watchdog_off, m[0]);
		`CHK(stop_allow, m[1]);
		`CHK(monitor_power_on, m[5]);
		`CHK(monitor_reset_allow, m[6]);
		`CHK(monitor_stop_keep, m[7]);
		`CHK(monitor_active, m[5] & (!in_stop | m[7]));
		`CHK(stop_wake_cycles, m[4] ? 32 : SLOW);
		`CHK(watchdog_period_cycles, m[3] ? 8192 - 16 : LONG);
	endtask
	task rst;
		@(posedge clk);
		srst <= 1'b1;
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		{m, done_m} = {8'h60, 1'b0};
		lv_m = 3'b000;
		repeat (2) @(posedge clk);
	endtask
	// falling pin high for k sampled edges
	task pulse(input int k);
		@(posedge clk);
		below <= 1'b1;
		repeat (k) @(posedge clk);
		below <= 1'b0;
		repeat (6) @(posedge clk);
		@(negedge clk);
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// main sequence
	initial begin
		{srst, below, in_stop, above, seed, n_fail, check_count} = '0;
		srst = 1'b1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
		{s_axi_arvalid, s_axi_rready, above, seed} = {2'b00, 1'b1, 32'h3b91};
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		rst();
		xfer(0, 8'h00, 0, 0);
		xfer(0, 8'h0C, 0, 0);
		chk_out();
		xfer(1, 8'h0C, 32'hFF, 4'hF);
		xfer(1, 8'h00, 32'h9A, 4'h0);
		xfer(0, 8'h04, 0, 0);
		$display("defaults done");
		for (int i = 0; i < 6; i++) begin
			v = $random(seed);
			v[4:3] = i[1:0];
			// fast wake is set only as software with an internal clock would
			xfer(1, 8'h00, v, 4'h1);
			in_stop <= v[8];
			chk_out();
			xfer(0, 8'h04, 0, 0);
			xfer(1, 8'h00, ~v, 4'hF);
			xfer(0, 8'h00, 0, 0);
			chk_out();
			rst();
			xfer(0, 8'h00, 0, 0);
		end
		$display("write once done");
		above <= 1'b0;
		for (int j = 0; j < 3; j++) begin
			rst();
			in_stop <= 1'b0;
			if (j < 2) xfer(1, 8'h00, j ? 32'h40 : 32'h20, 4'h1);
			pulse(8);
			`CHK(low_voltage_reset, 1'b0);
			pulse(9);
			`CHK(low_voltage_reset, j == 2);
		end
		repeat (20) @(posedge clk);
		`CHK(low_voltage_reset, 1'b1);
		lv_m = 3'b111;
		xfer(0, 8'h08, 0, 0);
		above <= 1'b1;
		repeat (6) @(posedge clk);
		@(negedge clk);
		`CHK(low_voltage_reset, 1'b0);
		lv_m = 3'b010;
		xfer(0, 8'h08, 0, 0);
		$display("monitor done");
		close_out();
	end
endmodule
